// file: rtl/frc_timer.sv
/*
 * 16-bit timer with four capture/compare registers, free-running and
 * pulse width measurement modes, overflow flag and plain register port
 * assumes capture pins are asynchronous; bus on SYS_CLK
 */
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module frc_timer (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WR_DATA,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    output logic      [15:0] RD_DATA,
    // capture pins
    input  wire logic [3:0]  CAPTURE_INPUT,
    // events and outputs
    output logic      [3:0]  CAPTURE_COMPARE_IRQ,
    output logic             COUNTER_OVERFLOW_IRQ,
    output logic      [3:0]  TIMER_OUTPUT
);
    frc_pkg::frc_state_type st_r, st_nxt;

    logic [4:0] edge_hit;
    logic [4:0] pin_src;
    logic [9:0] sel_src;
    logic [7:0] pre_mask;
    logic       tick;
    logic       run_free;
    logic       run_pw;
    logic       pw_clr;
    logic       ovf_set;
    logic       opt_wr;
    logic       bit_clr;
    localparam int CCS_TOP = frc_pkg::CCS_LSB + frc_pkg::NCH - 1;

    // ************************************************************
    // edge detectors: four capture channels plus external clock
    // ************************************************************
    assign pin_src = {CAPTURE_INPUT[0], CAPTURE_INPUT};
    assign sel_src = {st_r.extsel, st_r.edgesel};

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_det
            frc_edge_det u_det (
                .clk   (SYS_CLK),
                .rst_n (RST_N),
                .pin   (pin_src[g]),
                .sel   (sel_src[2*g+1 -: 2]),
                .hit   (edge_hit[g])
            );
        end
    endgenerate

    // ************************************************************
    // count clock and mode decode
    // ************************************************************
    assign pre_mask = 8'((9'h001 << st_r.cks) - 9'h001);
    assign tick     = st_r.ext ? edge_hit[4] : ((st_r.pre & pre_mask) == pre_mask);
    assign run_free = st_r.ce && (st_r.md == frc_pkg::MD_FREE);
    assign run_pw   = st_r.ce && (st_r.md == frc_pkg::MD_PW);
    assign pw_clr   = run_pw && (|edge_hit[3:0]);
    assign ovf_set  = (run_free || run_pw) && !pw_clr && tick
                      && (st_r.cnt == frc_pkg::CNT_MAX);
    assign opt_wr   = WR_STB && (ADDR == frc_pkg::A_OPT);
    assign bit_clr  = WR_STB && (ADDR == frc_pkg::A_OVCLR) && WR_DATA[frc_pkg::OVF_BIT];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt       = st_r;
        st_nxt.ccirq = '0;
        st_nxt.ovirq = 1'b0;
        st_nxt.rd    = '0;
        if (RD_STB) begin
            case (ADDR)
                frc_pkg::A_CTL0:  st_nxt.rd = {8'h00, st_r.ce, 4'h0, st_r.cks};
                frc_pkg::A_CTL1:  st_nxt.rd = {9'h000, st_r.ext, 3'h0, st_r.md};
                frc_pkg::A_OUTC:  st_nxt.rd = {8'h00, st_r.outc};
                frc_pkg::A_EDGE:  st_nxt.rd = {8'h00, st_r.edgesel};
                frc_pkg::A_EXTC:  st_nxt.rd = {14'h0000, st_r.extsel};
                frc_pkg::A_OPT:   st_nxt.rd = {8'h00, st_r.ccs, 3'h0, st_r.ovf};
                frc_pkg::A_CCR0:  st_nxt.rd = st_r.ccr[0];
                frc_pkg::A_CCR1:  st_nxt.rd = st_r.ccr[1];
                frc_pkg::A_CCR2:  st_nxt.rd = st_r.ccr[2];
                frc_pkg::A_CCR3:  st_nxt.rd = st_r.ccr[3];
                frc_pkg::A_CNT:   st_nxt.rd = st_r.cnt;
                default:          st_nxt.rd = '0;
            endcase
        end
        if (WR_STB) begin
            case (ADDR)
                frc_pkg::A_CTL0: begin
                    st_nxt.ce  = WR_DATA[frc_pkg::CE_BIT];
                    st_nxt.cks = WR_DATA[2:0];
                end
                frc_pkg::A_CTL1: begin
                    st_nxt.ext = WR_DATA[frc_pkg::EXT_BIT];
                    st_nxt.md  = WR_DATA[2:0];
                end
                frc_pkg::A_OUTC: st_nxt.outc    = WR_DATA[7:0];
                frc_pkg::A_EDGE: st_nxt.edgesel = WR_DATA[7:0];
                frc_pkg::A_EXTC: st_nxt.extsel  = WR_DATA[1:0];
                frc_pkg::A_OPT:  st_nxt.ccs     = WR_DATA[CCS_TOP:frc_pkg::CCS_LSB];
                frc_pkg::A_CCR0: st_nxt.ccr[0]  = WR_DATA;
                frc_pkg::A_CCR1: st_nxt.ccr[1]  = WR_DATA;
                frc_pkg::A_CCR2: st_nxt.ccr[2]  = WR_DATA;
                frc_pkg::A_CCR3: st_nxt.ccr[3]  = WR_DATA;
                default: ;
            endcase
        end
        // overflow flag: byte write of zero wins, set beats bit clear
        if (opt_wr && !WR_DATA[frc_pkg::OVF_BIT]) begin
            st_nxt.ovf = 1'b0;
        end else if (ovf_set) begin
            st_nxt.ovf = 1'b1;
        end else if (bit_clr) begin
            st_nxt.ovf = 1'b0;
        end
        // counter and channels
        if (!st_r.ce) begin
            st_nxt.cnt = frc_pkg::CNT_ZERO;
            st_nxt.pre = '0;
            st_nxt.tog = 1'b0;
        end else begin
            st_nxt.pre = st_r.pre + 8'h01;
            for (int m = 0; m < frc_pkg::NCH; m++) begin
                if (run_pw && edge_hit[m]) begin
                    st_nxt.ccr[m]   = st_r.cnt;
                    st_nxt.ccirq[m] = 1'b1;
                end else if (run_free && st_r.ccs[m] && edge_hit[m]) begin
                    st_nxt.ccr[m]   = st_r.cnt;
                    st_nxt.ccirq[m] = 1'b1;
                end else if (run_free && !st_r.ccs[m] && tick
                             && (st_r.cnt == st_r.ccr[m])) begin
                    st_nxt.ccirq[m] = 1'b1;
                    if (m == 0) begin
                        st_nxt.tog = ~st_r.tog;
                    end
                end
            end
            if (pw_clr) begin
                st_nxt.cnt = frc_pkg::CNT_ZERO;
            end else if (ovf_set) begin
                st_nxt.cnt   = frc_pkg::CNT_ZERO;
                st_nxt.ovirq = 1'b1;
            end else if ((run_free || run_pw) && tick) begin
                st_nxt.cnt = st_r.cnt + frc_pkg::CNT_ONE;
            end
        end
        // output pins: level from output control outside pulse width mode (all low there), toggling only free-run ch0
        for (int m = 0; m < frc_pkg::NCH; m++) begin
            st_nxt.tout[m] = st_nxt.outc[2*m+1];
        end
        if (st_nxt.md == frc_pkg::MD_FREE && !st_nxt.ccs[0] && st_nxt.outc[0]) begin
            st_nxt.tout[0] = st_nxt.outc[1] ^ st_nxt.tog;
        end
        if (st_nxt.md == frc_pkg::MD_PW) begin
            st_nxt.tout = '0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RD_DATA              = st_r.rd;
    assign CAPTURE_COMPARE_IRQ  = st_r.ccirq;
    assign COUNTER_OVERFLOW_IRQ = st_r.ovirq;
    assign TIMER_OUTPUT         = st_r.tout;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    logic ctl_wr;
    assign ctl_wr = WR_STB && (ADDR == frc_pkg::A_CTL0 || ADDR == frc_pkg::A_CTL1);

    sequence s_free_step;
        run_free && tick && !ctl_wr && st_r.cnt != frc_pkg::CNT_MAX;
    endsequence
    sequence s_wrap;
        ovf_set && !ctl_wr && !opt_wr;
    endsequence
    sequence s_pw_edge3;
        run_pw && edge_hit[3] && !ctl_wr && !(WR_STB && ADDR == frc_pkg::A_CCR3);
    endsequence
    sequence s_pw_steady;
        (st_r.md == frc_pkg::MD_PW)[*2];
    endsequence

    property p_free_count;
        s_free_step |=> st_r.cnt == $past(st_r.cnt) + frc_pkg::CNT_ONE;
    endproperty
    a_free_count: assert property (p_free_count)
        else $error("free-run counter did not advance by one");

    property p_wrap;
        s_wrap |=> (st_r.cnt == frc_pkg::CNT_ZERO) && COUNTER_OVERFLOW_IRQ && st_r.ovf;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("overflow did not wrap, flag and interrupt");

    property p_free_cap;
        run_free && st_r.ccs[2] && edge_hit[2] && !ctl_wr && !WR_STB
        |=> st_r.ccr[2] == $past(st_r.cnt) && CAPTURE_COMPARE_IRQ[2];
    endproperty
    a_free_cap: assert property (p_free_cap)
        else $error("free-run capture missed counter value");

    property p_pw_cap;
        s_pw_edge3 |=> st_r.cnt == frc_pkg::CNT_ZERO
                       ##0 st_r.ccr[3] == $past(st_r.cnt) ##0 CAPTURE_COMPARE_IRQ[3];
    endproperty
    a_pw_cap: assert property (p_pw_cap)
        else $error("pulse mode capture or clear failed");

    property p_set_wins;
        ovf_set && bit_clr |=> st_r.ovf;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("overflow lost to coincident bit clear");

    property p_byte_clear;
        opt_wr && !WR_DATA[frc_pkg::OVF_BIT] |=> !st_r.ovf;
    endproperty
    a_byte_clear: assert property (p_byte_clear)
        else $error("byte write of zero left flag set");

    property p_stop;
        !st_r.ce |=> st_r.cnt == frc_pkg::CNT_ZERO && !COUNTER_OVERFLOW_IRQ;
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter not held at zero while disabled");

    property p_pw_out;
        s_pw_steady |-> TIMER_OUTPUT == 4'h0;
    endproperty
    a_pw_out: assert property (p_pw_out)
        else $error("timer output driven in pulse width mode");

    property p_no_pw_count_stop;
        st_r.ce && st_r.md == frc_pkg::MD_PW && !pw_clr && tick && !ctl_wr
        && st_r.cnt != frc_pkg::CNT_MAX |=> st_r.cnt != frc_pkg::CNT_ZERO;
    endproperty
    a_no_pw_count_stop: assert property (p_no_pw_count_stop)
        else $error("pulse mode counter did not count");

    property p_rd_cnt;
        RD_STB && ADDR == frc_pkg::A_CNT |=> RD_DATA == $past(st_r.cnt);
    endproperty
    a_rd_cnt: assert property (p_rd_cnt)
        else $error("counter read returned wrong value");

    property p_rd_idle;
        !RD_STB |=> RD_DATA == frc_pkg::CNT_ZERO;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");

    property p_bit_clear;
        bit_clr && !ovf_set && !opt_wr |=> !st_r.ovf;
    endproperty
    a_bit_clear: assert property (p_bit_clear)
        else $error("bit clear left overflow flag set");

    property p_pw_flag;
        run_pw && ovf_set && !opt_wr |=> st_r.ovf && COUNTER_OVERFLOW_IRQ;
    endproperty
    a_pw_flag: assert property (p_pw_flag)
        else $error("pulse mode overflow did not set flag");

    property p_ovirq_pulse;
        COUNTER_OVERFLOW_IRQ |=> !COUNTER_OVERFLOW_IRQ;
    endproperty
    a_ovirq_pulse: assert property (p_ovirq_pulse)
        else $error("overflow interrupt longer than one cycle");
endmodule : frc_timer

// file: rtl/frc_pkg.sv
/*
 * constants and state types of the free-running / pulse-width capture timer
 * assumes a single clock and a plain strobe register port
 */
package frc_pkg;
    // ************************************************************
    // bus and widths
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int NCH    = 4;
    localparam int PRE_W  = 8;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [3:0] A_CTL0  = 4'h0;
    localparam logic [3:0] A_CTL1  = 4'h1;
    localparam logic [3:0] A_OUTC  = 4'h2;
    localparam logic [3:0] A_EDGE  = 4'h3;
    localparam logic [3:0] A_EXTC  = 4'h4;
    localparam logic [3:0] A_OPT   = 4'h5;
    localparam logic [3:0] A_OVCLR = 4'h6;
    localparam logic [3:0] A_CCR0  = 4'h8;
    localparam logic [3:0] A_CCR1  = 4'h9;
    localparam logic [3:0] A_CCR2  = 4'hA;
    localparam logic [3:0] A_CCR3  = 4'hB;
    localparam logic [3:0] A_CNT   = 4'hC;
    // ************************************************************
    // field positions and codes
    // ************************************************************
    localparam int CE_BIT  = 7;
    localparam int EXT_BIT = 6;
    localparam int OVF_BIT = 0;
    localparam int CCS_LSB = 4;
    localparam logic [2:0] MD_FREE = 3'h5;
    localparam logic [2:0] MD_PW   = 3'h6;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE  = 16'h0001;
    localparam logic [7:0]  REG_RST  = 8'h00;
    // ************************************************************
    // state types
    // ************************************************************
    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        s3;
    } frc_edge_state_type;
    typedef struct packed {
        logic             ce;
        logic [2:0]       cks;
        logic             ext;
        logic [2:0]       md;
        logic [7:0]       outc;
        logic [7:0]       edgesel;
        logic [1:0]       extsel;
        logic [3:0]       ccs;
        logic             ovf;
        logic [3:0][15:0] ccr;
        logic [15:0]      cnt;
        logic [7:0]       pre;
        logic             tog;
        logic [15:0]      rd;
        logic [3:0]       ccirq;
        logic             ovirq;
        logic [3:0]       tout;
    } frc_state_type;
endpackage : frc_pkg

// file: rtl/frc_edge_det.sv
/*
 * pin synchroniser and selectable edge detector for one input
 * assumes pin is asynchronous to clk
 */
`timescale 1ns/1ps
module frc_edge_det (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // pin and selection
    input  wire logic       pin,
    input  wire logic [1:0] sel,
    // detected edge
    output logic            hit
);
    frc_pkg::frc_edge_state_type st_r, st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // edge select, reads only the second and third stages
    // ************************************************************
    always_comb begin
        unique case (sel)
            frc_pkg::EDGE_RISE: hit = st_r.s2 & ~st_r.s3;
            frc_pkg::EDGE_FALL: hit = ~st_r.s2 & st_r.s3;
            frc_pkg::EDGE_BOTH: hit = st_r.s2 ^ st_r.s3;
            default:            hit = 1'b0;
        endcase
    end

    property p_hit_needs_change;
        @(posedge clk) disable iff (!rst_n) hit |-> (st_r.s2 != st_r.s3);
    endproperty
    a_hit_needs_change: assert property (p_hit_needs_change)
        else $error("edge reported without a level change");
endmodule : frc_edge_det

// file: dv/frc_pulse_src.sv
/*
 * model of the external pulse sources on the capture pins
 * assumes one bench command per pin change
 */
`timescale 1ns/1ps
module frc_pulse_src (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // command
    input  wire logic       fire,
    input  wire logic [1:0] fire_ch,
    // pins
    output logic      [3:0] pins
);
    // ********
    // pin levels
    // ********
    // a level holds until the next command, so pulses last over two clocks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins <= 4'h0;
        end else if (fire) begin
            pins[fire_ch] <= ~pins[fire_ch];
        end
    end
endmodule : frc_pulse_src

// file: dv/tb_top.sv
/*
 * self-checking bench for frc_timer
 * assumes frc_pulse_src on the capture pins and one 125 MHz clock
 */
`timescale 1ns/1ps
module tb_top;
    // ********
    // signals
    // ********
    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic [3:0]  addr    = 4'h0;
    logic [15:0] wr_data = 16'h0000;
    logic        wr_stb  = 1'b0;
    logic        rd_stb  = 1'b0;
    logic [15:0] rd_data;
    logic [3:0]  pins;
    logic [3:0]  cc_irq;
    logic        ov_irq;
    logic [3:0]  tout;
    logic        fire    = 1'b0;
    logic [1:0]  fire_ch = 2'h0;
    int          fail_count  = 0;
    int          comparisons = 0;
    int          ov_seen     = 0;
    int          cc_seen [4] = '{0, 0, 0, 0};
    // ********
    // instances
    // ********
    frc_timer frc_timer_i (.SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data), .CAPTURE_INPUT(pins),
        .CAPTURE_COMPARE_IRQ(cc_irq), .COUNTER_OVERFLOW_IRQ(ov_irq), .TIMER_OUTPUT(tout));
    frc_pulse_src frc_pulse_src_i (.clk(clk), .rst_n(rst_n), .fire(fire),
        .fire_ch(fire_ch), .pins(pins));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ov_irq === 1'b1) ov_seen++;
        for (int i = 0; i < 4; i++) if (cc_irq[i] === 1'b1) cc_seen[i]++;
    end
    // ********
    // tasks
    // ********
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk);
        wr_stb  <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp, input string name);
        logic [15:0] d;
        rd(a, d);
        check(name, d, exp);
    endtask : rdchk
    task automatic pulse(input logic [1:0] c);
        @(posedge clk);
        fire    <= 1'b1;
        fire_ch <= c;
        @(posedge clk);
        fire    <= 1'b0;
    endtask : pulse
    task automatic wait_irq(input int c, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (cc_irq[c] !== 1'b1 && n < 2000);
        if (n >= 2000) check("irq wait", 16'h0001, 16'h0000);
    endtask : wait_irq
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    // ********
    // scenarios
    // ********
    task automatic t_regs;
        rdchk(frc_pkg::A_OPT, 16'h0000, "opt reset");
        rdchk(frc_pkg::A_CNT, 16'h0000, "cnt reset");
        rdchk(4'h7, 16'h0000, "unmapped");
        @(posedge clk);
        #1;
        check("idle rd_data", rd_data, 16'h0000);
        wr(frc_pkg::A_OPT, 16'h00FF);
        rdchk(frc_pkg::A_OPT, 16'h00F0, "opt write one");
        $display("test regs done");
    endtask : t_regs
    task automatic t_free;
        int n;
        int ov0;
        logic [15:0] v, w;
        wr(frc_pkg::A_CTL1, {13'h0000, frc_pkg::MD_FREE});
        wr(frc_pkg::A_EDGE, 16'h0014);
        wr(frc_pkg::A_OPT, 16'h0060);
        wr(frc_pkg::A_OUTC, 16'h0001);
        wr(frc_pkg::A_CCR0, 16'h00FF);
        wr(frc_pkg::A_CTL0, 16'h0080);
        wait_irq(0, n);
        wr(frc_pkg::A_CCR0, 16'h01FF);
        check("out0 toggled", {15'h0000, tout[0]}, 16'h0001);
        wait_irq(0, n);
        check("interval", 16'(n + 2), 16'd256);
        check("out0 back", {15'h0000, tout[0]}, 16'h0000);
        ov0 = ov_seen;
        pulse(2'h1);
        repeat (98) @(posedge clk);
        pulse(2'h2);
        wait_irq(2, n);
        rd(frc_pkg::A_CCR1, v);
        rd(frc_pkg::A_CCR2, w);
        check("capture spacing", w - v, 16'd100);
        check("overflows between captures", 16'(ov_seen - ov0), 16'h0000);
        rd(frc_pkg::A_CNT, v);
        check("no clear", {15'h0000, v > w}, 16'h0001);
        rd(frc_pkg::A_CNT, v);
        repeat (int'(16'hFFFD) - int'(v)) @(posedge clk);
        ov0 = ov_seen;
        wr(frc_pkg::A_OVCLR, 16'h0001);
        rdchk(frc_pkg::A_CNT, 16'h0001, "wrap");
        rdchk(frc_pkg::A_OPT, 16'h0061, "set beats clear");
        check("overflow irq", 16'(ov_seen - ov0), 16'h0001);
        wr(frc_pkg::A_OVCLR, 16'h0001);
        rdchk(frc_pkg::A_OPT, 16'h0060, "bit clear");
        wr(frc_pkg::A_OPT, 16'h0060);
        rdchk(frc_pkg::A_OPT, 16'h0060, "byte clear");
        $display("test free done");
    endtask : t_free
    task automatic t_pulse;
        int n;
        int c;
        int ov0;
        wr(frc_pkg::A_CTL0, 16'h0000);
        rdchk(frc_pkg::A_CNT, 16'h0000, "stop clears");
        wr(frc_pkg::A_CTL1, {13'h0000, frc_pkg::MD_PW});
        wr(frc_pkg::A_EDGE, 16'h0040);
        wr(frc_pkg::A_OPT, 16'h0000);
        wr(frc_pkg::A_OUTC, 16'h0003);
        wr(frc_pkg::A_CTL0, 16'h0080);
        ov0 = ov_seen;
        pulse(2'h3);
        repeat (18) @(posedge clk);
        pulse(2'h3);
        repeat (178) @(posedge clk);
        pulse(2'h3);
        wait_irq(3, n);
        rdchk(frc_pkg::A_CNT, 16'h0001, "cleared");
        rdchk(frc_pkg::A_CCR3, 16'd199, "pulse width");
        check("pulse overflows", 16'(ov_seen - ov0), 16'h0000);
        check("outputs idle", {12'h000, tout}, 16'h0000);
        c = cc_seen[2];
        pulse(2'h2);
        pulse(2'h2);
        repeat (10) @(posedge clk);
        check("unused input", 16'(cc_seen[2] - c), 16'h0000);
        wr(frc_pkg::A_CTL0, 16'h0000);
        rdchk(frc_pkg::A_CNT, 16'h0000, "stopped");
        wr(frc_pkg::A_CTL0, 16'h0082);
        repeat (40) @(posedge clk);
        rdchk(frc_pkg::A_CNT, 16'h000A, "prescaled count");
        $display("test pulse done");
    endtask : t_pulse
    // ********
    // sequence and watchdog
    // ********
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_free();
        t_pulse();
        stop_test();
    end
    initial begin
        #(8 * 90000);
        fail_count++;
        $display("watchdog expired");
        stop_test();
    end
endmodule : tb_top
